// [rtl/driver_status_consts.vh]
// Purpose: Constants for the motor driver status word block
// Assumes: 100 MHz core clock, 32-bit APB
// Notes:   Offsets are byte addresses
`ifndef DRIVER_STATUS_CONSTS_VH
`define DRIVER_STATUS_CONSTS_VH

// ****************************************
// Register offsets
// ****************************************
`define OFS_DRIVER_STATUS_WORD 12'h000
`define OFS_IRQ_STATUS         12'h004
`define OFS_IRQ_MASK           12'h008
`define OFS_DRIVER_CONTROL     12'h00C

// ****************************************
// Status word field positions
// ****************************************
`define BIT_STANDSTILL         31
`define BIT_OPEN_LOAD_B        30
`define BIT_OPEN_LOAD_A        29
`define BIT_GROUND_SHORT_B     28
`define BIT_GROUND_SHORT_A     27
`define BIT_TEMP_PREWARN       26
`define BIT_THERMAL_SHUTDOWN   25
`define BIT_STALL              24
`define CUR_SCALE_MSB          20
`define CUR_SCALE_LSB          16
`define BIT_FULL_STEP          15

// ****************************************
// Control register fields and reset values
// ****************************************
`define OFF_TIME_MSB           3
`define OFF_TIME_LSB           0
`define CONTROL_RESET          4'h0
`define IRQ_MASK_RESET         8'h00

// ****************************************
// Timing
// ****************************************
`define STANDSTILL_CYCLES      21'h100000
`define STANDSTILL_CNT_W       21

`endif

// [rtl/pin_sync.v]
// Purpose: Three-stage synchroniser for an asynchronous pin level
// Assumes: Single clock domain, active high async reset
// Notes:   Output changes only when stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module pin_sync (
   // Clock and reset
   input  wire core_clk_i,
   input  wire rst_i,
   input  wire clk_en_i,
   // Pin
   input  wire pin_i,
   output reg  level_o
);
   reg s1_reg;
   reg s2_reg;
   reg s3_reg;

   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         s1_reg  <= 1'b0;
         s2_reg  <= 1'b0;
         s3_reg  <= 1'b0;
         level_o <= 1'b0;
      end else if (clk_en_i) begin
         s1_reg <= pin_i;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg == s3_reg) begin
            level_o <= s3_reg;
         end
      end
   end
endmodule // pin_sync
`default_nettype wire

// [rtl/standstill_timer.v]
// Purpose: Counts clocks since the last step pulse
// Assumes: Step pulse is a one-cycle event in the core domain
// Notes:   Saturates so the flag holds until the next step
`timescale 1ns/1ns
`default_nettype none
`include "driver_status_consts.vh"
module standstill_timer #(
   parameter [`STANDSTILL_CNT_W-1:0] LIMIT = `STANDSTILL_CYCLES
) (
   // Clock and reset
   input  wire core_clk_i,
   input  wire rst_i,
   input  wire clk_en_i,
   // Step event and result
   input  wire step_i,
   output reg  standstill_o
);
   reg [`STANDSTILL_CNT_W-1:0] cnt_reg;

   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_reg      <= {`STANDSTILL_CNT_W{1'b0}};
         standstill_o <= 1'b0;
      end else if (clk_en_i) begin
         if (step_i) begin
            cnt_reg      <= {`STANDSTILL_CNT_W{1'b0}};
            standstill_o <= 1'b0;
         end else if (cnt_reg != LIMIT) begin
            cnt_reg      <= cnt_reg + {{(`STANDSTILL_CNT_W-1){1'b0}}, 1'b1};
            standstill_o <= (cnt_reg == LIMIT - {{(`STANDSTILL_CNT_W-1){1'b0}}, 1'b1});
         end
      end
   end
endmodule // standstill_timer
`default_nettype wire

// [rtl/driver_status_flags.v]
// Purpose: Status word of a two-phase motor driver, on APB
// Assumes: Detector levels come from analog blocks, asynchronous
// Notes:   Adds event status, mask and a small control register
//
// Notes on behaviour
// - Standstill bit 31 sets 2^20 clocks after the last step pulse.
// - Open load B in bit 30, A in bit 29; informative only.
// - Ground short sets bit 28 (B) or 27 (A), disables driver.
// - Ground-short flags hold until off-time is 0 or disable pin.
// - Bit 26 follows shared overtemperature prewarning.
// - Shutdown bit 25 keeps bridges off until prewarning clears too.
// - Bit 24 reports stall from active load measurement or commutation.
// - Bits 20:16 show the actual current scaling value.
// - Bit 15 is 0 microstepping, 1 in full-step operation.
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "driver_status_consts.vh"
module driver_status_flags #(
   parameter [`STANDSTILL_CNT_W-1:0] STANDSTILL_LIMIT = `STANDSTILL_CYCLES
) (
   // Clock, reset, enable
   input  wire        core_clk_i,
   input  wire        rst_i,
   input  wire        clk_en_i,
   // APB slave
   input  wire        psel_i,
   input  wire        penable_i,
   input  wire        pwrite_i,
   input  wire [11:0] paddr_i,
   input  wire [31:0] pwdata_i,
   output reg  [31:0] prdata_o,
   output reg         pready_o,
   output reg         pslverr_o,
   // Core-side events and values
   input  wire        step_pulse_i,
   input  wire        stall_load_i,
   input  wire        stall_commutation_i,
   input  wire        commutation_mode_i,
   input  wire [4:0]  current_scale_i,
   input  wire        full_step_i,
   // Analog detector pins
   input  wire        open_load_a_pin_i,
   input  wire        open_load_b_pin_i,
   input  wire        ground_short_a_pin_i,
   input  wire        ground_short_b_pin_i,
   input  wire        temp_prewarn_pin_i,
   input  wire        temp_limit_pin_i,
   input  wire        driver_disable_input_i,
   // Outputs
   output reg         bridge_enable_o,
   output reg         irq_o
);

   // ****************************************
   // Pin synchronisers
   // ****************************************
   wire [6:0] pin_raw;
   wire [6:0] pin_sync_lvl;
   assign pin_raw = {driver_disable_input_i, temp_limit_pin_i, temp_prewarn_pin_i,
                     ground_short_b_pin_i, ground_short_a_pin_i,
                     open_load_b_pin_i, open_load_a_pin_i};

   genvar g;
   generate
      for (g = 0; g < 7; g = g + 1) begin : g_sync
         pin_sync u_sync (
            .core_clk_i (core_clk_i),
            .rst_i      (rst_i),
            .clk_en_i   (clk_en_i),
            .pin_i      (pin_raw[g]),
            .level_o    (pin_sync_lvl[g])
         );
      end
   endgenerate

   wire open_load_a;
   wire open_load_b;
   wire short_a_det;
   wire short_b_det;
   wire temp_prewarn;
   wire temp_limit;
   wire drv_disabled_pin;
   assign open_load_a      = pin_sync_lvl[0];
   assign open_load_b      = pin_sync_lvl[1];
   assign short_a_det      = pin_sync_lvl[2];
   assign short_b_det      = pin_sync_lvl[3];
   assign temp_prewarn     = pin_sync_lvl[4];
   assign temp_limit       = pin_sync_lvl[5];
   assign drv_disabled_pin = pin_sync_lvl[6];

   // ****************************************
   // Standstill
   // ****************************************
   wire standstill;
   standstill_timer #(
      .LIMIT (STANDSTILL_LIMIT)
   ) u_standstill (
      .core_clk_i   (core_clk_i),
      .rst_i        (rst_i),
      .clk_en_i     (clk_en_i),
      .step_i       (step_pulse_i),
      .standstill_o (standstill)
   );

   // ****************************************
   // Registers
   // ****************************************
   reg  [3:0]  chopper_off_time_reg;
   reg  [7:0]  irq_mask_reg;
   reg  [7:0]  irq_status_reg;
   reg  [7:0]  irq_status_next;
   reg         ground_short_phase_a_reg;
   reg         ground_short_phase_b_reg;
   reg         thermal_shutdown_flag_reg;
   reg         stall_reg;
   reg  [4:0]  cur_scale_reg;
   reg         full_step_reg;
   reg  [7:0]  flags_prev_reg;

   wire driver_off;
   wire setup_ph;
   wire wr_acc;
   wire rd_acc;
   wire [7:0] flags_now;
   wire [7:0] flag_rise;
   wire [31:0] status_word;

   // Driver counts as disabled by zero off-time or the disable pin
   assign driver_off = (chopper_off_time_reg == 4'h0) || drv_disabled_pin;

   assign setup_ph = psel_i && !penable_i;
   assign wr_acc   = psel_i && penable_i && pready_o && pwrite_i;
   assign rd_acc   = setup_ph && !pwrite_i;

   assign status_word = {standstill, open_load_b, open_load_a,
                         ground_short_phase_b_reg, ground_short_phase_a_reg,
                         temp_prewarn, thermal_shutdown_flag_reg,
                         stall_reg, 3'h0, cur_scale_reg,
                         full_step_reg, 15'h0000};

   assign flags_now = status_word[31:24];
   assign flag_rise = flags_now & ~flags_prev_reg;

   // ****************************************
   // Fault flags and bridge enable
   // ****************************************
   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ground_short_phase_a_reg  <= 1'b0;
         ground_short_phase_b_reg  <= 1'b0;
         thermal_shutdown_flag_reg <= 1'b0;
         stall_reg                 <= 1'b0;
         cur_scale_reg             <= 5'h00;
         full_step_reg             <= 1'b0;
         bridge_enable_o           <= 1'b0;
      end else if (clk_en_i) begin
         // Detection wins over the release condition
         if (short_a_det) begin
            ground_short_phase_a_reg <= 1'b1;
         end else if (driver_off) begin
            ground_short_phase_a_reg <= 1'b0;
         end
         if (short_b_det) begin
            ground_short_phase_b_reg <= 1'b1;
         end else if (driver_off) begin
            ground_short_phase_b_reg <= 1'b0;
         end
         // Hysteresis: release only once prewarning has also gone
         if (temp_limit) begin
            thermal_shutdown_flag_reg <= 1'b1;
         end else if (!temp_prewarn) begin
            thermal_shutdown_flag_reg <= 1'b0;
         end
         stall_reg     <= commutation_mode_i ? stall_commutation_i : stall_load_i;
         cur_scale_reg <= current_scale_i;
         full_step_reg <= full_step_i;
         // Open-load flags take no part here: informative only
         bridge_enable_o <= !driver_off && !short_a_det && !short_b_det
                            && !ground_short_phase_a_reg && !ground_short_phase_b_reg
                            && !temp_limit && !thermal_shutdown_flag_reg;
      end
   end

   // ****************************************
   // Event status and interrupt
   // ****************************************
   always @* begin
      irq_status_next = irq_status_reg;
      if (wr_acc && paddr_i == `OFS_IRQ_STATUS) begin
         irq_status_next = irq_status_next & ~pwdata_i[7:0];
      end
      // Set wins over a simultaneous clear
      irq_status_next = irq_status_next | flag_rise;
   end

   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         irq_status_reg <= 8'h00;
         flags_prev_reg <= 8'h00;
         irq_o          <= 1'b0;
      end else if (clk_en_i) begin
         irq_status_reg <= irq_status_next;
         flags_prev_reg <= flags_now;
         irq_o          <= |(irq_status_next & irq_mask_reg);
      end
   end

   // ****************************************
   // APB slave
   // ****************************************
   // No wait state: data are latched in setup, pready in access
   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         prdata_o             <= 32'h00000000;
         pready_o             <= 1'b0;
         pslverr_o            <= 1'b0;
         chopper_off_time_reg <= `CONTROL_RESET;
         irq_mask_reg         <= `IRQ_MASK_RESET;
      end else if (clk_en_i) begin
         pready_o  <= setup_ph;
         pslverr_o <= 1'b0;
         if (setup_ph) begin
            case (paddr_i)
               `OFS_DRIVER_STATUS_WORD,
               `OFS_IRQ_STATUS,
               `OFS_IRQ_MASK,
               `OFS_DRIVER_CONTROL: pslverr_o <= 1'b0;
               default:             pslverr_o <= 1'b1;
            endcase
         end
         if (rd_acc) begin
            // Reading never touches a flag
            case (paddr_i)
               `OFS_DRIVER_STATUS_WORD: prdata_o <= status_word;
               `OFS_IRQ_STATUS:         prdata_o <= {24'h000000, irq_status_next};
               `OFS_IRQ_MASK:           prdata_o <= {24'h000000, irq_mask_reg};
               `OFS_DRIVER_CONTROL:     prdata_o <= {28'h0000000, chopper_off_time_reg};
               default:                 prdata_o <= 32'h00000000;
            endcase
         end
         if (wr_acc) begin
            // Status word has no write path
            case (paddr_i)
               `OFS_IRQ_MASK:       irq_mask_reg <= pwdata_i[7:0];
               `OFS_DRIVER_CONTROL: chopper_off_time_reg <= pwdata_i[`OFF_TIME_MSB:`OFF_TIME_LSB];
               default:             irq_mask_reg <= irq_mask_reg;
            endcase
         end
      end
   end

endmodule // driver_status_flags
`default_nettype wire

// [testbench/driver_status_flags_sva.sv]
// Purpose: Concurrent checks on the driver status block ports
// Assumes: Clock enable held high, single clock domain
// Notes:   Pin levels are held long enough to pass the synchroniser
`timescale 1ns/1ns
`default_nettype none
module driver_status_checker (
   // Clock and reset
   input wire logic        core_clk_i,
   input wire logic        rst_i,
   // APB
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] prdata_o,
   input wire logic        pready_o,
   input wire logic        pslverr_o,
   // Core side and pins
   input wire logic        stall_load_i,
   input wire logic        commutation_mode_i,
   input wire logic [4:0]  current_scale_i,
   input wire logic        full_step_i,
   input wire logic        open_load_a_pin_i,
   input wire logic        ground_short_a_pin_i,
   input wire logic        temp_prewarn_pin_i,
   input wire logic        temp_limit_pin_i,
   input wire logic        bridge_enable_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   // Setup phase of a status word read
   wire rd0 = psel_i && !penable_i && !pwrite_i && paddr_i == 12'h000;
   property p_ready; psel_i && !penable_i |=> pready_o ##1 !pready_o; endproperty
   a_ready: assert property (p_ready) else $error("ready not a single pulse");
   property p_unmap; psel_i && !penable_i && !pwrite_i && paddr_i[11:4] != 8'h00
      |=> pslverr_o && prdata_o == 32'h0; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not refused");
   property p_stswr; psel_i && !penable_i && pwrite_i && paddr_i == 12'h000 |=> !pslverr_o; endproperty
   a_stswr: assert property (p_stswr) else $error("status write errored");
   property p_gnd; ground_short_a_pin_i [*8] |-> !bridge_enable_o; endproperty
   a_gnd: assert property (p_gnd) else $error("bridge on during short");
   property p_limit; temp_limit_pin_i [*8] |-> !bridge_enable_o; endproperty
   a_limit: assert property (p_limit) else $error("bridge on during overtemp");
   property p_warn; temp_prewarn_pin_i [*8] ##0 rd0 |=> prdata_o[26]; endproperty
   a_warn: assert property (p_warn) else $error("prewarning not shown");
   property p_open; open_load_a_pin_i [*8] ##0 rd0 |=> prdata_o[29]; endproperty
   a_open: assert property (p_open) else $error("open load A not shown");
   property p_scale; $stable(current_scale_i) [*3] ##0 rd0
      |=> prdata_o[20:16] == $past(current_scale_i); endproperty
   a_scale: assert property (p_scale) else $error("scale value wrong");
   property p_full; full_step_i [*3] ##0 rd0 |=> prdata_o[15]; endproperty
   a_full: assert property (p_full) else $error("full step not shown");
   property p_stall; (!commutation_mode_i && stall_load_i) [*3] ##0 rd0 |=> prdata_o[24]; endproperty
   a_stall: assert property (p_stall) else $error("stall not shown");
endmodule // driver_status_checker
bind driver_status_flags driver_status_checker u_chk (.core_clk_i, .rst_i, .psel_i, .penable_i,
   .pwrite_i, .paddr_i, .prdata_o, .pready_o, .pslverr_o, .stall_load_i, .commutation_mode_i,
   .current_scale_i, .full_step_i, .open_load_a_pin_i, .ground_short_a_pin_i,
   .temp_prewarn_pin_i, .temp_limit_pin_i, .bridge_enable_o);
`default_nettype wire

// [testbench/driver_status_flags_bench.sv]
// Purpose: Self-checking bench for the driver status block
// Assumes: Standstill limit cut to 16 cycles
// Notes:   Pins held 8 cycles so the synchroniser settles
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin miscompares++; \
   $display("BAD %s exp %0h got %0h", nm, ex, got); end end
module driver_status_flags_bench;
   localparam logic [20:0] SL = 21'h000010;
   logic core_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic clk_en_i = 1'b1;
   logic psel_i, penable_i, pwrite_i, step_pulse_i, stall_load_i, stall_commutation_i;
   logic commutation_mode_i, full_step_i, open_load_a_pin_i, open_load_b_pin_i;
   logic ground_short_a_pin_i, ground_short_b_pin_i, temp_prewarn_pin_i, temp_limit_pin_i;
   logic driver_disable_input_i;
   logic [11:0] paddr_i;
   logic [31:0] pwdata_i, rd;
   logic [4:0] current_scale_i;
   logic er;
   wire logic [31:0] prdata_o;
   wire logic pready_o, pslverr_o, bridge_enable_o, irq_o;
   int miscompares, n_tests, cycles;
   driver_status_flags #(.STANDSTILL_LIMIT(SL)) u_dut (.core_clk_i, .rst_i, .clk_en_i, .psel_i,
      .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .step_pulse_i,
      .stall_load_i, .stall_commutation_i, .commutation_mode_i, .current_scale_i, .full_step_i,
      .open_load_a_pin_i, .open_load_b_pin_i, .ground_short_a_pin_i, .ground_short_b_pin_i,
      .temp_prewarn_pin_i, .temp_limit_pin_i, .driver_disable_input_i, .bridge_enable_o, .irq_o);
   always #5 core_clk_i = ~core_clk_i;
   // ****************************************
   // Bus and helpers
   // ****************************************
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge core_clk_i);
      penable_i <= 1'b1;
      // Look at pready mid-cycle, away from the edge that launches it
      do begin
         @(negedge core_clk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 50);
      if (n == 50) miscompares++;
      rd = prdata_o;
      er = pslverr_o;
      @(posedge core_clk_i);
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      // Idle edge so the next call never reassigns psel in this time step
      @(posedge core_clk_i);
   endtask
   task automatic wt(int n);
      repeat (n) @(posedge core_clk_i);
   endtask
   task automatic rs;
      apb(1'b0, 12'h000, 32'h0);
   endtask
   task automatic print_verdict;
      $display("Checks %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_regs;
      apb(1'b1, 12'h000, 32'hFFFFFFFF);
      `CHK("st wr err", 1'b0, er)
      rs;
      `CHK("status", 32'h0, rd & 32'h7FFFFFFF)
      apb(1'b0, 12'h00C, 32'h0);
      `CHK("ctrl", 32'h0, rd)
      apb(1'b0, 12'h040, 32'h0);
      `CHK("unmapped", 1'b1, er)
   endtask
   task automatic t_stst;
      step_pulse_i <= 1'b1;
      @(posedge core_clk_i);
      step_pulse_i <= 1'b0;
      wt(SL - 6);
      rs;
      `CHK("stst early", 1'b0, rd[31])
      wt(8);
      rs;
      `CHK("stst", 1'b1, rd[31])
   endtask
   task automatic t_gnd;
      apb(1'b1, 12'h00C, 32'h5);
      wt(8);
      `CHK("bridge on", 1'b1, bridge_enable_o)
      ground_short_b_pin_i <= 1'b1;
      wt(8);
      `CHK("bridge off", 1'b0, bridge_enable_o)
      ground_short_b_pin_i <= 1'b0;
      wt(8);
      rs;
      `CHK("gsb held", 1'b1, rd[28])
      apb(1'b1, 12'h00C, 32'h0);
      wt(8);
      rs;
      `CHK("gsb clr", 1'b0, rd[28])
      apb(1'b1, 12'h00C, 32'h5);
      ground_short_a_pin_i <= 1'b1;
      wt(8);
      rs;
      `CHK("gsa", 1'b1, rd[27])
      ground_short_a_pin_i <= 1'b0;
      driver_disable_input_i <= 1'b1;
      wt(8);
      rs;
      `CHK("gsa clr", 1'b0, rd[27])
      driver_disable_input_i <= 1'b0;
   endtask
   task automatic t_therm;
      apb(1'b1, 12'h00C, 32'h5);
      temp_prewarn_pin_i <= 1'b1;
      temp_limit_pin_i <= 1'b1;
      wt(8);
      rs;
      `CHK("warn lim", 2'b11, rd[26:25])
      `CHK("bridge ot", 1'b0, bridge_enable_o)
      temp_limit_pin_i <= 1'b0;
      wt(8);
      rs;
      `CHK("ot held", 2'b11, rd[26:25])
      `CHK("bridge hold", 1'b0, bridge_enable_o)
      temp_prewarn_pin_i <= 1'b0;
      wt(8);
      rs;
      `CHK("ot clr", 2'b00, rd[26:25])
      `CHK("bridge back", 1'b1, bridge_enable_o)
   endtask
   // Pins change only while no step is applied: flags read at standstill
   task automatic t_open;
      open_load_a_pin_i <= 1'b1;
      open_load_b_pin_i <= 1'b1;
      wt(8);
      rs;
      `CHK("open", 2'b11, rd[30:29])
      `CHK("open drv", 1'b1, bridge_enable_o)
      open_load_b_pin_i <= 1'b0;
      wt(8);
      rs;
      `CHK("open a", 2'b01, rd[30:29])
      open_load_a_pin_i <= 1'b0;
   endtask
   task automatic t_core;
      logic [4:0] sv [3] = '{5'h1F, 5'h15, 5'h00};
      foreach (sv[i]) begin
         current_scale_i <= sv[i];
         full_step_i <= i[0];
         wt(3);
         rs;
         `CHK("scale", sv[i], rd[20:16])
         `CHK("fstep", i[0], rd[15])
      end
      stall_load_i <= 1'b1;
      wt(3);
      rs;
      `CHK("stall load", 1'b1, rd[24])
      commutation_mode_i <= 1'b1;
      wt(3);
      rs;
      `CHK("stall mode", 1'b0, rd[24])
      stall_commutation_i <= 1'b1;
      wt(3);
      rs;
      `CHK("stall comm", 1'b1, rd[24])
      {stall_load_i, stall_commutation_i, commutation_mode_i} <= 3'b000;
   endtask
   task automatic t_irq;
      apb(1'b1, 12'h004, 32'hFF);
      apb(1'b0, 12'h004, 32'h0);
      `CHK("ev clr", 32'h0, rd)
      stall_load_i <= 1'b1;
      wt(3);
      apb(1'b0, 12'h004, 32'h0);
      apb(1'b0, 12'h004, 32'h0);
      `CHK("ev stall", 32'h1, rd)
      `CHK("irq masked", 1'b0, irq_o)
      apb(1'b1, 12'h008, 32'h1);
      wt(2);
      `CHK("irq", 1'b1, irq_o)
      stall_load_i <= 1'b0;
      apb(1'b1, 12'h004, 32'h1);
      wt(2);
      `CHK("irq clr", 1'b0, irq_o)
   endtask
   // ****************************************
   // Main sequence and watchdog
   // ****************************************
   always @(posedge core_clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         print_verdict;
      end
   end
   initial begin
      {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, step_pulse_i, stall_load_i, stall_commutation_i,
       commutation_mode_i, current_scale_i, full_step_i, open_load_a_pin_i, open_load_b_pin_i,
       ground_short_a_pin_i, ground_short_b_pin_i, temp_prewarn_pin_i, temp_limit_pin_i,
       driver_disable_input_i} = '0;
      repeat (4) @(posedge core_clk_i);
      rst_i <= 1'b0;
      @(posedge core_clk_i);
      t_regs;
      t_stst;
      t_gnd;
      t_therm;
      t_open;
      t_core;
      t_irq;
      print_verdict;
   end
endmodule // driver_status_flags_bench
`default_nettype wire
